// ### logic/t8wm_pkg.sv
package t8wm_pkg;
	localparam logic [7:0] OFF_OUT_MODE = 8'h00;
	localparam logic [7:0] OFF_CLK_FORCE = 8'h04;
	localparam logic [7:0] OFF_COUNTER = 8'h08;
	localparam logic [7:0] OFF_CMP_A = 8'h0c;
	localparam logic [7:0] OFF_CMP_B = 8'h10;
	localparam logic [7:0] OFF_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h18;
	localparam int POS_COM_A = 6;
	localparam int POS_COM_B = 4;
	localparam int POS_FORCE_A = 7;
	localparam int POS_FORCE_B = 6;
	localparam int POS_MODE_TWO = 3;
	localparam int EV_OVF = 0;
	localparam int EV_MATCH_A = 1;
	localparam int EV_MATCH_B = 2;
	localparam logic [7:0] CNT_MAX = 8'hff;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [2:0] MODE_NORMAL = 3'h0;
	localparam logic [2:0] MODE_PC_FF = 3'h1;
	localparam logic [2:0] MODE_CLR_MATCH = 3'h2;
	localparam logic [2:0] MODE_FAST_FF = 3'h3;
	localparam logic [2:0] MODE_PC_CMP = 3'h5;
	localparam logic [2:0] MODE_FAST_CMP = 3'h7;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIV1 = 3'h1;
	localparam logic [2:0] CS_DIV8 = 3'h2;
	localparam logic [2:0] CS_DIV64 = 3'h3;
	localparam logic [2:0] CS_DIV256 = 3'h4;
	localparam logic [2:0] CS_DIV1024 = 3'h5;
	localparam logic [2:0] CS_EXT_FALL = 3'h6;
	localparam logic [2:0] CS_EXT_RISE = 3'h7;
	localparam logic [9:0] PSC_LAST_8 = 10'h007;
	localparam logic [9:0] PSC_LAST_64 = 10'h03f;
	localparam logic [9:0] PSC_LAST_256 = 10'h0ff;
	localparam logic [9:0] PSC_LAST_1024 = 10'h3ff;
	typedef enum logic {T8WM_UP, T8WM_DOWN} t8wm_dir_t;
endpackage

// ### logic/t8wm_top.sv
`timescale 1ns/100ps
module t8wm_top import t8wm_pkg::*; (
	input wire logic ref_clk_i,
	input wire logic resetn_i,
	input wire logic hsel_i,
	input wire logic [7:0] haddr_i,
	input wire logic [1:0] htrans_i,
	input wire logic hwrite_i,
	input wire logic [2:0] hsize_i,
	input wire logic [31:0] hwdata_i,
	input wire logic hready_i,
	output logic [31:0] hrdata_o,
	output logic hreadyout_o,
	output logic hresp_o,
	input wire logic ext_clk_i,
	input wire logic dir_a_i,
	input wire logic dir_b_i,
	input wire logic port_a_i,
	input wire logic port_b_i,
	output logic pin_a_o,
	output logic pin_a_oe_n_o,
	output logic pin_b_o,
	output logic pin_b_oe_n_o,
	output logic irq_o
);

	typedef struct packed {
		logic [1:0] com_a;
		logic [1:0] com_b;
		logic [2:0] mode;
		logic [2:0] cs;
		logic [7:0] cnt;
		logic [7:0] cmp_a_buf;
		logic [7:0] cmp_b_buf;
		logic [7:0] cmp_a;
		logic [7:0] cmp_b;
		t8wm_dir_t dir;
		logic blk;
		logic [9:0] psc;
		logic ext_q;
		logic wave_a;
		logic wave_b;
		logic [2:0] status;
		logic [2:0] mask;
		logic irq;
		logic pin_a;
		logic pin_a_oe_n;
		logic pin_b;
		logic pin_b_oe_n;
		logic dp_wr;
		logic [7:0] dp_addr;
		logic [31:0] hrdata;
		logic hreadyout;
		logic hresp;
	} t8wm_state_t;

	t8wm_state_t state_ff;
	t8wm_state_t nxt_state;
	logic tick;
	logic pwm;
	logic fast;
	logic pc;
	logic rsvd_mode;
	logic [7:0] top;
	logic at_top;
	logic hit_a;
	logic hit_b;
	logic ovf;
	logic load;
	logic addr_ph;

	////////////////////////////////////////////////////////////////////////////////
	// Next level of one waveform output
	function automatic logic chan_next(input logic [1:0] com, input logic is_b,
		input logic cur, input logic hit, input logic top_ev, input logic cmp_top,
		input logic [2:0] mode, input t8wm_dir_t dir);
		logic r;
		r = cur;
		if (!mode[0]) begin
			if (hit) begin
				case (com)
					2'b01: r = ~cur;
					2'b10: r = 1'b0;
					2'b11: r = 1'b1;
					default: r = cur;
				endcase
			end
		end else if (com[1]) begin
			if (cmp_top) begin
				// Match at TOP is dropped so the level stays constant
				if (top_ev) begin
					r = ~com[0];
				end
			end else begin
				if (hit) begin
					r = (mode[1] || dir == T8WM_UP) ? com[0] : ~com[0];
				end
				if (mode[1] && top_ev) begin
					r = ~com[0];
				end
			end
		end else if (com == 2'b01 && !is_b && mode[2] && hit) begin
			r = ~cur;
		end
		return r;
	endfunction

	// Pin belongs to the waveform unless the setting is off or reserved
	function automatic logic chan_conn(input logic [1:0] com, input logic is_b,
		input logic [2:0] mode);
		logic r;
		r = (com != 2'b00);
		if (mode[0] && com == 2'b01 && (is_b || !mode[2])) begin
			r = 1'b0;
		end
		return r;
	endfunction

	// Read view of a register
	function automatic logic [31:0] reg_read(input t8wm_state_t q, input logic [7:0] a);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (a)
			OFF_OUT_MODE: r = {24'h00_0000, q.com_a, q.com_b, 2'b00, q.mode[1:0]};
			OFF_CLK_FORCE: r = {24'h00_0000, 4'h0, q.mode[2], q.cs};
			OFF_COUNTER: r = {24'h00_0000, q.cnt};
			OFF_CMP_A: r = {24'h00_0000, q.cmp_a_buf};
			OFF_CMP_B: r = {24'h00_0000, q.cmp_b_buf};
			OFF_IRQ_STATUS: r = {29'h0000_0000, q.status};
			OFF_IRQ_MASK: r = {29'h0000_0000, q.mask};
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	////////////////////////////////////////////////////////////////////////////////
	// Mode decode and timer clock
	always_comb begin
		pwm = state_ff.mode[0];
		fast = state_ff.mode[1] & state_ff.mode[0];
		pc = ~state_ff.mode[1] & state_ff.mode[0];
		rsvd_mode = state_ff.mode[2] & ~state_ff.mode[0];
		top = (state_ff.mode == MODE_CLR_MATCH || state_ff.mode[2]) ?
			state_ff.cmp_a : CNT_MAX;
		case (state_ff.cs)
			CS_STOP: tick = 1'b0;
			CS_DIV1: tick = 1'b1;
			CS_DIV8: tick = (state_ff.psc[2:0] == PSC_LAST_8[2:0]);
			CS_DIV64: tick = (state_ff.psc[5:0] == PSC_LAST_64[5:0]);
			CS_DIV256: tick = (state_ff.psc[7:0] == PSC_LAST_256[7:0]);
			CS_DIV1024: tick = (state_ff.psc == PSC_LAST_1024);
			CS_EXT_FALL: tick = state_ff.ext_q & ~ext_clk_i;
			CS_EXT_RISE: tick = ~state_ff.ext_q & ext_clk_i;
			default: tick = 1'b0;
		endcase
		// Reserved modes hold the counter rather than guess a sequence
		if (rsvd_mode) begin
			tick = 1'b0;
		end
		at_top = tick & (state_ff.cnt == top);
		hit_a = tick & ~state_ff.blk & (state_ff.cnt == state_ff.cmp_a);
		hit_b = tick & ~state_ff.blk & (state_ff.cnt == state_ff.cmp_b);
		load = pwm & at_top;
		case (state_ff.mode)
			MODE_NORMAL, MODE_CLR_MATCH, MODE_FAST_FF: ovf = tick & (state_ff.cnt == CNT_MAX);
			MODE_PC_FF, MODE_PC_CMP: ovf = tick & (state_ff.cnt == CNT_BOTTOM);
			MODE_FAST_CMP: ovf = at_top;
			default: ovf = 1'b0;
		endcase
		addr_ph = hsel_i & hready_i & htrans_i[1];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Next state
	always_comb begin
		nxt_state = state_ff;
		nxt_state.ext_q = ext_clk_i;
		nxt_state.psc = state_ff.psc + 10'h001;
		if (tick) begin
			nxt_state.blk = 1'b0;
			if (pc) begin
				if (state_ff.dir == T8WM_UP) begin
					if (state_ff.cnt == top) begin
						nxt_state.dir = T8WM_DOWN;
						nxt_state.cnt = state_ff.cnt - 8'h01;
					end else begin
						nxt_state.cnt = state_ff.cnt + 8'h01;
					end
				end else if (state_ff.cnt == CNT_BOTTOM) begin
					nxt_state.dir = T8WM_UP;
					nxt_state.cnt = state_ff.cnt + 8'h01;
				end else begin
					nxt_state.cnt = state_ff.cnt - 8'h01;
				end
			end else begin
				nxt_state.cnt = (state_ff.cnt == top) ? CNT_BOTTOM : state_ff.cnt + 8'h01;
			end
		end
		if (!pwm || load) begin
			nxt_state.cmp_a = state_ff.cmp_a_buf;
			nxt_state.cmp_b = state_ff.cmp_b_buf;
		end
		nxt_state.wave_a = chan_next(state_ff.com_a, 1'b0, state_ff.wave_a, hit_a,
			at_top, state_ff.cmp_a == top, state_ff.mode, state_ff.dir);
		nxt_state.wave_b = chan_next(state_ff.com_b, 1'b1, state_ff.wave_b, hit_b,
			at_top, state_ff.cmp_b == top, state_ff.mode, state_ff.dir);
		// Data phase of a write
		if (state_ff.dp_wr) begin
			case (state_ff.dp_addr)
				OFF_OUT_MODE: begin
					nxt_state.com_a = hwdata_i[POS_COM_A +: 2];
					nxt_state.com_b = hwdata_i[POS_COM_B +: 2];
					nxt_state.mode[1:0] = hwdata_i[1:0];
				end
				OFF_CLK_FORCE: begin
					nxt_state.mode[2] = hwdata_i[POS_MODE_TWO];
					nxt_state.cs = hwdata_i[2:0];
					// Forced match uses the mode held before this write
					if (!pwm && hwdata_i[POS_FORCE_A]) begin
						nxt_state.wave_a = chan_next(state_ff.com_a, 1'b0, state_ff.wave_a,
							1'b1, 1'b0, 1'b0, state_ff.mode, state_ff.dir);
					end
					if (!pwm && hwdata_i[POS_FORCE_B]) begin
						nxt_state.wave_b = chan_next(state_ff.com_b, 1'b1, state_ff.wave_b,
							1'b1, 1'b0, 1'b0, state_ff.mode, state_ff.dir);
					end
				end
				OFF_COUNTER: begin
					// A written count masks the compare on the next timer clock
					nxt_state.cnt = hwdata_i[7:0];
					nxt_state.blk = 1'b1;
				end
				OFF_CMP_A: nxt_state.cmp_a_buf = hwdata_i[7:0];
				OFF_CMP_B: nxt_state.cmp_b_buf = hwdata_i[7:0];
				OFF_IRQ_MASK: nxt_state.mask = hwdata_i[2:0];
				default: nxt_state.mask = state_ff.mask;
			endcase
		end
		// Address phase; reads are sampled here, zero wait states
		nxt_state.dp_wr = addr_ph & hwrite_i;
		nxt_state.dp_addr = haddr_i;
		nxt_state.hrdata = 32'h0000_0000;
		if (addr_ph && !hwrite_i) begin
			nxt_state.hrdata = reg_read(state_ff, haddr_i);
			if (haddr_i == OFF_IRQ_STATUS) begin
				nxt_state.status = 3'h0;
			end
		end
		// Set wins over the read clear; forced matches raise nothing
		nxt_state.status[EV_OVF] = nxt_state.status[EV_OVF] | ovf;
		nxt_state.status[EV_MATCH_A] = nxt_state.status[EV_MATCH_A] | hit_a;
		nxt_state.status[EV_MATCH_B] = nxt_state.status[EV_MATCH_B] | hit_b;
		nxt_state.irq = |(nxt_state.status & nxt_state.mask);
		nxt_state.hreadyout = 1'b1;
		nxt_state.hresp = 1'b0;
		nxt_state.pin_a = chan_conn(nxt_state.com_a, 1'b0, nxt_state.mode) ?
			nxt_state.wave_a : port_a_i;
		nxt_state.pin_b = chan_conn(nxt_state.com_b, 1'b1, nxt_state.mode) ?
			nxt_state.wave_b : port_b_i;
		nxt_state.pin_a_oe_n = ~dir_a_i;
		nxt_state.pin_b_oe_n = ~dir_b_i;
	end

	always_ff @(posedge ref_clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			state_ff <= '0;
			state_ff.dir <= T8WM_UP;
			state_ff.pin_a_oe_n <= 1'b1;
			state_ff.pin_b_oe_n <= 1'b1;
			state_ff.hreadyout <= 1'b1;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign hrdata_o = state_ff.hrdata;
	assign hreadyout_o = state_ff.hreadyout;
	assign hresp_o = state_ff.hresp;
	assign pin_a_o = state_ff.pin_a;
	assign pin_a_oe_n_o = state_ff.pin_a_oe_n;
	assign pin_b_o = state_ff.pin_b;
	assign pin_b_oe_n_o = state_ff.pin_b_oe_n;
	assign irq_o = state_ff.irq;

	////////////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!resetn_i);

	chk_rsvd_bits_zero: assert property (
		addr_ph && !hwrite_i && haddr_i == OFF_OUT_MODE |=> hrdata_o[3:2] == 2'b00)
		else $error("reserved output mode bits read nonzero");
	chk_force_reads_zero: assert property (
		addr_ph && !hwrite_i && haddr_i == OFF_CLK_FORCE |=> hrdata_o[7:4] == 4'h0)
		else $error("force bits read nonzero");
	// Reset sampled low at the release edge keeps the first attempt vacuous
	chk_pin_port_mux: assert property (
		resetn_i && state_ff.com_a == 2'b00 && nxt_state.com_a == 2'b00
		|=> pin_a_o == $past(port_a_i))
		else $error("pin A not left to port");
	chk_pin_b_enable: assert property (
		resetn_i |=> pin_b_oe_n_o == !$past(dir_b_i))
		else $error("pin B enable wrong");
	chk_ctc_clear: assert property (
		state_ff.mode == MODE_CLR_MATCH && tick && state_ff.cnt == state_ff.cmp_a
		&& !state_ff.dp_wr |=> state_ff.cnt == CNT_BOTTOM)
		else $error("clear-on-match did not restart");
	chk_ovf_normal: assert property (
		state_ff.mode == MODE_NORMAL && tick && state_ff.cnt == CNT_MAX
		|=> state_ff.status[EV_OVF] ##1 irq_o == state_ff.mask[EV_OVF] || state_ff.status[2:1] != 0)
		else $error("overflow missed at MAX");
	chk_ovf_bottom: assert property (
		pc && tick && state_ff.cnt == CNT_BOTTOM |=> state_ff.status[EV_OVF])
		else $error("overflow missed at BOTTOM");
	chk_clear_match_a: assert property (
		state_ff.mode == MODE_NORMAL && state_ff.com_a == 2'b10 && hit_a && !state_ff.dp_wr
		|=> !state_ff.wave_a ##1 1'b1)
		else $error("A not cleared on match");
	chk_fast_top_set: assert property (
		state_ff.mode == MODE_FAST_FF && state_ff.com_a == 2'b10 && at_top && !state_ff.dp_wr
		|=> state_ff.wave_a)
		else $error("A not set at TOP");
	chk_pc_up_clear: assert property (
		pc && state_ff.com_a == 2'b10 && hit_a && state_ff.dir == T8WM_UP
		&& state_ff.cmp_a != top && !state_ff.dp_wr |=> !state_ff.wave_a)
		else $error("A not cleared on up match");
	chk_cmp_hold_pwm: assert property (
		pwm && !load |=> $stable(state_ff.cmp_a) && $stable(state_ff.cmp_b))
		else $error("compare changed away from TOP");
	chk_force_no_flag: assert property (
		state_ff.dp_wr && state_ff.dp_addr == OFF_CLK_FORCE && !hit_a && !hit_b && !ovf
		&& !addr_ph |=> $stable(state_ff.status))
		else $error("forced match raised a flag");
	chk_ovf_fast_top: assert property (
		state_ff.mode == MODE_FAST_CMP && at_top |=> state_ff.status[EV_OVF])
		else $error("overflow missed at TOP");
	chk_pc_down_set: assert property (
		pc && state_ff.com_a == 2'b10 && hit_a && state_ff.dir == T8WM_DOWN
		&& state_ff.cmp_a != top && !state_ff.dp_wr |=> state_ff.wave_a)
		else $error("A not set on down match");
	chk_top_const: assert property (
		pwm && state_ff.com_a[1] && state_ff.cmp_a == top && at_top && !state_ff.dp_wr
		|=> state_ff.wave_a == !$past(state_ff.com_a[0]))
		else $error("A wrong at TOP with compare at TOP");
	chk_ctc_toggle: assert property (
		!pwm && state_ff.com_a == 2'b01 && hit_a && !state_ff.dp_wr
		|=> state_ff.wave_a != $past(state_ff.wave_a))
		else $error("A not toggled on match");
	chk_fast_b_clear: assert property (
		fast && state_ff.com_b == 2'b10 && hit_b && !at_top && !state_ff.dp_wr
		|=> !state_ff.wave_b)
		else $error("B not cleared on match");
	chk_pc_b_up_set: assert property (
		pc && state_ff.com_b == 2'b11 && hit_b && state_ff.dir == T8WM_UP
		&& state_ff.cmp_b != top && !state_ff.dp_wr |=> state_ff.wave_b)
		else $error("B not set on up match");
	chk_ext_rise: assert property (
		state_ff.cs == CS_EXT_RISE && !rsvd_mode && !state_ff.ext_q && ext_clk_i && !pc
		&& state_ff.cnt != top && !state_ff.dp_wr |=> state_ff.cnt == $past(state_ff.cnt) + 8'h01)
		else $error("rising pin edge not counted");

	chk_irq_level: assert property (
		irq_o == |(state_ff.status & state_ff.mask))
		else $error("interrupt level wrong");

	cov_fast_toggle: cover property (state_ff.mode == MODE_FAST_CMP && state_ff.com_a == 2'b01 && hit_a);
	cov_pc_turn: cover property (pc && at_top ##1 state_ff.dir == T8WM_DOWN);
	cov_irq_rise: cover property (!irq_o ##1 irq_o);
	cov_force_a: cover property (state_ff.dp_wr && state_ff.dp_addr == OFF_CLK_FORCE
		&& hwdata_i[POS_FORCE_A] && !pwm);
	cov_top_const: cover property (pwm && state_ff.com_a[1] && state_ff.cmp_a == top && at_top);

endmodule // t8wm_top

// ### tb/t8wm_pin_model.sv
`timescale 1ns/100ps
module t8wm_pin_model (
	input wire logic ref_clk_i,
	input wire logic pin_i,
	input wire logic oe_n_i,
	output logic level_o
);
	logic last_ff;
	always_ff @(posedge ref_clk_i) begin
		if (!oe_n_i) begin
			last_ff <= pin_i;
		end
	end
	// Released pin has no pull, so show a changed level instead of a stale one
	assign level_o = oe_n_i ? ~last_ff : pin_i;
endmodule // t8wm_pin_model

// ### tb/tb_top.sv
`timescale 1ns/100ps
module tb_top;
	import t8wm_pkg::*;
	logic clk, rst_n, hsel, hwrite, ext, dir_a, dir_b, prt_a, prt_b;
	logic [7:0] haddr;
	logic [1:0] htrans;
	logic [31:0] hwdata, hrdata, rd;
	logic rdy, resp, pa, pa_n, pb, pb_n, irq, lv_a, lv_b;
	int mismatches = 0;
	int cmp_count = 0;
	t8wm_top t8wm_top_i (.ref_clk_i(clk), .resetn_i(rst_n), .hsel_i(hsel), .haddr_i(haddr),
		.htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2), .hwdata_i(hwdata),
		.hready_i(rdy), .hrdata_o(hrdata), .hreadyout_o(rdy), .hresp_o(resp),
		.ext_clk_i(ext), .dir_a_i(dir_a), .dir_b_i(dir_b), .port_a_i(prt_a),
		.port_b_i(prt_b), .pin_a_o(pa), .pin_a_oe_n_o(pa_n), .pin_b_o(pb),
		.pin_b_oe_n_o(pb_n), .irq_o(irq));
	t8wm_pin_model t8wm_pin_model_a_i (.ref_clk_i(clk), .pin_i(pa), .oe_n_i(pa_n), .level_o(lv_a));
	t8wm_pin_model t8wm_pin_model_b_i (.ref_clk_i(clk), .pin_i(pb), .oe_n_i(pb_n), .level_o(lv_b));
	initial begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic test_done;
		if (mismatches == 0 && cmp_count > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic wait_rdy;
		for (int i = 0; i < 50; i++) begin
			@(posedge clk);
			if (rdy === 1'b1) return;
		end
		mismatches++;
		$display("ERROR hready expected 1 seen %b", rdy);
		test_done;
	endtask
	// Address phase held until hready, then data phase until hready again
	task automatic bus(input logic [7:0] a, input logic w, input logic [31:0] d);
		@(posedge clk);
		hsel <= 1'b1;
		haddr <= a;
		hwrite <= w;
		htrans <= 2'b10;
		wait_rdy;
		hsel <= 1'b0;
		htrans <= 2'b00;
		hwdata <= d;
		wait_rdy;
		rd = hrdata;
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task automatic t_regs;
		bus(OFF_OUT_MODE, 1'b1, 32'h000000ff);
		bus(OFF_OUT_MODE, 1'b0, 32'h0);
		chk("out_mode", 32'h000000f3, rd);
		bus(OFF_CLK_FORCE, 1'b1, 32'h00000008);
		bus(OFF_CLK_FORCE, 1'b0, 32'h0);
		chk("clk_force", 32'h00000008, rd);
		bus(8'h40, 1'b0, 32'h0);
		chk("unmapped", 32'h0, rd);
		chk("hresp", 32'h0, {31'h0, resp});
		bus(OFF_CLK_FORCE, 1'b1, 32'h0);
		bus(OFF_OUT_MODE, 1'b1, 32'h0);
	endtask
	task automatic t_force;
		logic [7:0] om [4] = '{8'hf0, 8'ha0, 8'h50, 8'h50};
		logic ex [4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		for (int i = 0; i < 4; i++) begin
			bus(OFF_OUT_MODE, 1'b1, {24'h0, om[i]});
			bus(OFF_CLK_FORCE, 1'b1, 32'h000000c0);
			bus(OFF_CLK_FORCE, 1'b0, 32'h0);
			chk("force read", 32'h0, rd);
			chk("pin a", {31'h0, ex[i]}, {31'h0, lv_a});
			chk("pin b", {31'h0, ex[i]}, {31'h0, lv_b});
		end
		bus(OFF_IRQ_STATUS, 1'b0, 32'h0);
		chk("force flag", 32'h0, rd);
	endtask
	task automatic t_port;
		bus(OFF_OUT_MODE, 1'b1, 32'h0);
		@(posedge clk);
		dir_a <= 1'b0;
		prt_a <= 1'b1;
		prt_b <= 1'b0;
		repeat (3) @(posedge clk);
		chk("oe_n a", 32'h1, {31'h0, pa_n});
		chk("port b", 32'h0, {31'h0, pb});
		chk("oe_n b", 32'h0, {31'h0, pb_n});
		dir_a <= 1'b1;
		repeat (3) @(posedge clk);
		chk("port a", 32'h1, {31'h0, lv_a});
	endtask
	task automatic t_ext;
		logic [7:0] cs [2] = '{8'h07, 8'h06};
		for (int k = 0; k < 2; k++) begin
			bus(OFF_COUNTER, 1'b1, 32'h0);
			bus(OFF_CLK_FORCE, 1'b1, {24'h0, cs[k]});
			// Pin idles high, so each pulse starts low to give three edges of each kind
			for (int i = 0; i < 3; i++) begin
				ext <= 1'b0;
				repeat (4) @(posedge clk);
				ext <= 1'b1;
				repeat (4) @(posedge clk);
			end
			bus(OFF_CLK_FORCE, 1'b1, 32'h0);
			bus(OFF_COUNTER, 1'b0, 32'h0);
			chk("ext count", 32'h3, rd);
		end
	endtask
	task automatic t_ovf;
		bus(OFF_IRQ_STATUS, 1'b0, 32'h0);
		bus(OFF_CMP_A, 1'b1, 32'h40);
		bus(OFF_CMP_B, 1'b1, 32'h40);
		bus(OFF_COUNTER, 1'b1, 32'hf0);
		bus(OFF_CLK_FORCE, 1'b1, {29'h0, CS_DIV1});
		repeat (30) @(posedge clk);
		bus(OFF_CLK_FORCE, 1'b1, 32'h0);
		bus(OFF_IRQ_MASK, 1'b1, 32'h1);
		@(negedge clk);
		chk("irq", 32'h1, {31'h0, irq});
		bus(OFF_IRQ_STATUS, 1'b0, 32'h0);
		chk("status", 32'h1, rd);
		bus(OFF_IRQ_STATUS, 1'b0, 32'h0);
		chk("cleared", 32'h0, rd);
		@(negedge clk);
		chk("irq off", 32'h0, {31'h0, irq});
	endtask
	task automatic t_psc;
		logic [2:0] sel [4] = '{CS_DIV8, CS_DIV64, CS_DIV256, CS_DIV1024};
		int div [4] = '{8, 64, 256, 1024};
		bus(OFF_CLK_FORCE, 1'b1, 32'h0);
		bus(OFF_OUT_MODE, 1'b1, 32'h0);
		for (int k = 0; k < 4; k++) begin
			bus(OFF_COUNTER, 1'b1, 32'h0);
			bus(OFF_CLK_FORCE, 1'b1, {29'h0, sel[k]});
			// Ten periods plus two edges hold ten ticks unless a tick falls on one of the first two edges
			repeat (10 * div[k] - 1) @(posedge clk);
			bus(OFF_CLK_FORCE, 1'b1, 32'h0);
			bus(OFF_COUNTER, 1'b0, 32'h0);
			chk("prescaled count", 32'h0000000a, rd);
		end
	endtask
	// Duty of the resolved pin level over a window of whole periods, after a warm-up
	task automatic duty(input logic b, input logic [7:0] om, input logic [7:0] cf,
		input logic [7:0] cv, input int win, input int lo, input int hi);
		int n;
		n = 0;
		bus(OFF_CLK_FORCE, 1'b1, 32'h0);
		bus(b ? OFF_CMP_B : OFF_CMP_A, 1'b1, {24'h0, cv});
		bus(OFF_OUT_MODE, 1'b1, {24'h0, om});
		bus(OFF_CLK_FORCE, 1'b1, {24'h0, cf});
		repeat (600) @(posedge clk);
		for (int i = 0; i < win; i++) begin
			@(negedge clk);
			n += int'(b ? lv_b : lv_a);
		end
		cmp_count++;
		if (n < lo || n > hi) begin
			mismatches++;
			$display("ERROR duty %h expected %0d..%0d seen %0d", om, lo, hi, n);
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst_n = 1'b0;
		{hsel, hwrite, ext, dir_a, dir_b, prt_a, prt_b} = 7'h1f;
		haddr = 8'h0;
		htrans = 2'b00;
		hwdata = 32'h0;
		repeat (10) @(posedge clk);
		rst_n <= 1'b1;
		t_regs;
		t_force;
		t_port;
		t_ext;
		t_ovf;
		duty(1'b0, 8'h83, 8'h01, 8'h80, 256, 120, 136);
		duty(1'b0, 8'hc3, 8'h01, 8'h80, 256, 120, 136);
		duty(1'b0, 8'h83, 8'h01, 8'hff, 256, 252, 256);
		duty(1'b0, 8'h43, 8'h09, 8'h09, 200, 90, 110);
		duty(1'b0, 8'h42, 8'h01, 8'h05, 240, 110, 130);
		duty(1'b0, 8'h81, 8'h01, 8'h80, 510, 245, 265);
		duty(1'b1, 8'h23, 8'h01, 8'h40, 256, 58, 72);
		duty(1'b1, 8'h31, 8'h01, 8'h40, 510, 370, 395);
		duty(1'b1, 8'h21, 8'h09, 8'h40, 256, 120, 136);
		t_psc;
		test_done;
	end
	initial begin
		#2000000;
		mismatches++;
		$display("ERROR run time expected done seen timeout");
		test_done;
	end
endmodule // tb_top
